// file: shared/stsync_map.vh
// Behaviour
// - Internal 1.024 MHz oscillator is the default time base.
// - External clock may come on master clock or bit clock pin, 1.024-24.576 MHz; the code has one ext_clk_i input for any nonzero source code.
// - Divider field bits 7:4 divides external clock to 1024 or 256 kHz.
// - PDM needs 768 kHz or 1.024 MHz; code 0011 divides 3.072 MHz by four.
// - External trigger only in low-power chain modes, with either clock.
// - Each accepted trigger pulse yields exactly one output sample.
// - Trigger config bit 1 selects input pin, bit 0 enables triggering.
// - External sync only in low-noise chain modes, with either clock.
// - Active sync shifts sample-ready phase to align with sync input.
// - Sync config bit 6 selects frame-sync or interrupt-one pin.
// - Sync mode bits 5:4: 00 none, 01 sync, 10 interpolated sync.
// - Mode zero default: sample on system clock, ready per new sample.
// - Clock control bits 1:0 choose internal or external clock source.
// - Mode 01 aligns sample-ready to every sync pulse received.
// - Mode 10 outputs linear interpolation of last two samples, one period late.
`ifndef STSYNC_MAP_VH
`define STSYNC_MAP_VH
`define STS_ADDR_CLOCK_CONTROL   8'h25
`define STS_ADDR_SYNC_CONFIG     8'h35
`define STS_ADDR_TRIGGER_CONFIG  8'h49
`define STS_ADDR_CHAIN_MODE      8'h50
`define STS_ADDR_STATUS          8'h51
`define STS_ADDR_SAMPLE_DATA     8'h52
`define STS_ADDR_SAMPLE_CONFIG   8'h53
`define STS_RST_CLOCK_CONTROL    8'h00
`define STS_RST_SYNC_CONFIG      8'h00
`define STS_RST_TRIGGER_CONFIG   8'h00
`define STS_RST_CHAIN_MODE       3'h0
`define STS_RST_ODR_DIV          8'h40
`define STS_DIV_HI               7
`define STS_DIV_LO               4
`define STS_SRC_HI               1
`define STS_SRC_LO               0
`define STS_SYNC_SEL_BIT         6
`define STS_SYNC_MODE_HI         5
`define STS_SYNC_MODE_LO         4
`define STS_TRIG_SEL_BIT         1
`define STS_TRIG_EN_BIT          0
`define STS_SYNC_NONE            2'h0
`define STS_SYNC_EXT             2'h1
`define STS_SYNC_INTERP          2'h2
`define STS_SRC_INTERNAL         2'h0
`define STS_MODE_HP              3'h0
`define STS_MODE_RBW             3'h1
`define STS_MODE_LPSD            3'h2
`define STS_MODE_VLP             3'h3
`define STS_MODE_ULP             3'h4
`define STS_MODE_HS              3'h5
`define STS_MODE_STANDBY         3'h7
`define STS_CLK_MHZ_X1000        50000
`define STS_OSC_KHZ              1024
`define STS_PULSE_MIN_NS         5700
`endif

// file: src/stsync_interp.v
`timescale 1ns/10ps
`default_nettype none
// Holds the two newest samples and forms their linear average on request
module stsync_interp #(
   parameter W = 16
) (
   input  wire         clk_i,
   input  wire         sys_rst_i,
   input  wire         push_i,
   input  wire [W-1:0] sample_i,
   input  wire         take_i,
   output reg  [W-1:0] interp_o
);
   reg  [W-1:0] newest_q;
   reg  [W-1:0] older_q;
   wire [W:0]   sum = {1'b0, newest_q} + {1'b0, older_q};

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         newest_q <= {W{1'b0}};
         older_q  <= {W{1'b0}};
         interp_o <= {W{1'b0}};
      end else begin
         if (push_i) begin
            newest_q <= sample_i;
            older_q  <= newest_q;
         end
         if (take_i) begin
            interp_o <= sum[W:1];
         end
      end
   end
endmodule // stsync_interp
`default_nettype wire

// file: src/stsync_top.v
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "stsync_map.vh"
module stsync_top #(
   parameter W = 16
) (
   input  wire         clk_i,
   input  wire         sys_rst_i,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [31:0]  paddr,
   input  wire [31:0]  pwdata,
   output wire         pready,
   output reg  [31:0]  prdata,
   output wire         pslverr,
   input  wire         ext_clk_i,
   input  wire         frame_sync_pin_i,
   input  wire         interrupt_pin_one_i,
   input  wire [W-1:0] raw_sample_i,
   output reg          sample_ready_o,
   output reg  [W-1:0] sample_data_o,
   output reg          sys_tick_o
);
   localparam [15:0] OSC_DIV = (`STS_CLK_MHZ_X1000 + `STS_OSC_KHZ - 1) / `STS_OSC_KHZ;
   localparam [15:0] PULSE_CYC = (`STS_PULSE_MIN_NS + 19) / 20;
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_WAIT = 4'h2;
   localparam [3:0] ST_EMIT = 4'h4;
   localparam [3:0] ST_HOLD = 4'h8;

   reg  [7:0]  clock_control_q;
   reg  [7:0]  sync_config_q;
   reg  [7:0]  trigger_config_q;
   reg  [2:0]  chain_mode_q;
   reg  [7:0]  odr_div_q;
   reg  [2:0]  fs_q;
   reg  [2:0]  i1_q;
   reg  [2:0]  ec_q;
   reg         fs_lvl_q;
   reg         i1_lvl_q;
   reg         ec_lvl_q;
   reg         trig_prev_q;
   reg         sync_prev_q;
   reg         ec_prev_q;
   reg  [15:0] osc_cnt_q;
   reg  [3:0]  ext_cnt_q;
   reg  [7:0]  odr_cnt_q;
   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg         sample_ready_d;
   reg         synced_flag_q;
   reg         trig_pending_q;
   reg  [7:0]  sample_cnt_q;

   wire        bus_wr = psel & penable & pwrite;
   wire [7:0]  reg_idx = paddr[9:2];
   wire        mapped;
   wire        ext_sel = clock_control_q[`STS_SRC_HI:`STS_SRC_LO] != `STS_SRC_INTERNAL;
   wire [1:0]  sync_mode = sync_config_q[`STS_SYNC_MODE_HI:`STS_SYNC_MODE_LO];
   wire        low_power = (chain_mode_q == `STS_MODE_VLP) | (chain_mode_q == `STS_MODE_ULP)
                           | (chain_mode_q == `STS_MODE_HS);
   wire        low_noise = (chain_mode_q == `STS_MODE_HP) | (chain_mode_q == `STS_MODE_RBW)
                           | (chain_mode_q == `STS_MODE_LPSD);
   wire        standby = chain_mode_q == `STS_MODE_STANDBY;
   wire        trig_lvl = trigger_config_q[`STS_TRIG_SEL_BIT] ? i1_lvl_q : fs_lvl_q;
   wire        sync_lvl = sync_config_q[`STS_SYNC_SEL_BIT] ? i1_lvl_q : fs_lvl_q;
   wire        trig_edge = trig_lvl & ~trig_prev_q;
   wire        sync_edge = sync_lvl & ~sync_prev_q;
   wire        trig_on = trigger_config_q[`STS_TRIG_EN_BIT] & low_power;
   wire        sync_on = (sync_mode != `STS_SYNC_NONE) & low_noise;
   wire        osc_tick = osc_cnt_q == OSC_DIV - 16'h0001;
   wire        ext_edge = ec_lvl_q & ~ec_prev_q;
   wire        ext_tick = ext_edge & (ext_cnt_q == clock_control_q[`STS_DIV_HI:`STS_DIV_LO]);
   wire        tick = ext_sel ? ext_tick : osc_tick;
   // Compare with >= so that a smaller divider written mid-count takes effect on the next tick
   wire        odr_tick = tick & (odr_cnt_q >= odr_div_q - 8'h01);
   wire        push = (odr_tick & ~trig_on) | (state_q == ST_EMIT);
   wire [W-1:0] interp_val;

   function is_reg;
      input [7:0] idx;
      begin
         is_reg = (idx == `STS_ADDR_CLOCK_CONTROL) | (idx == `STS_ADDR_SYNC_CONFIG)
                | (idx == `STS_ADDR_TRIGGER_CONFIG) | (idx == `STS_ADDR_CHAIN_MODE)
                | (idx == `STS_ADDR_STATUS) | (idx == `STS_ADDR_SAMPLE_DATA)
                | (idx == `STS_ADDR_SAMPLE_CONFIG);
      end
   endfunction

   assign mapped  = is_reg(reg_idx) & (paddr[31:10] == 22'h0) & (paddr[1:0] == 2'h0);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Registers; the divider and source only accept writes in standby
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         clock_control_q  <= `STS_RST_CLOCK_CONTROL;
         sync_config_q    <= `STS_RST_SYNC_CONFIG;
         trigger_config_q <= `STS_RST_TRIGGER_CONFIG;
         chain_mode_q     <= `STS_MODE_STANDBY;
         odr_div_q        <= `STS_RST_ODR_DIV;
      end else if (bus_wr & mapped) begin
         case (reg_idx)
            `STS_ADDR_CLOCK_CONTROL: begin
               if (standby) begin
                  clock_control_q <= pwdata[7:0];
               end
            end
            `STS_ADDR_SYNC_CONFIG:    sync_config_q    <= pwdata[7:0];
            `STS_ADDR_TRIGGER_CONFIG: trigger_config_q <= pwdata[7:0];
            `STS_ADDR_CHAIN_MODE:     chain_mode_q     <= pwdata[2:0];
            `STS_ADDR_SAMPLE_CONFIG: begin
               if (pwdata[7:0] != 8'h00) begin
                  odr_div_q <= pwdata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata <= 32'h0;
      end else if (psel & ~penable & ~pwrite) begin
         case (reg_idx)
            `STS_ADDR_CLOCK_CONTROL:  prdata <= {24'h0, clock_control_q};
            `STS_ADDR_SYNC_CONFIG:    prdata <= {24'h0, sync_config_q};
            `STS_ADDR_TRIGGER_CONFIG: prdata <= {24'h0, trigger_config_q};
            `STS_ADDR_CHAIN_MODE:     prdata <= {29'h0, chain_mode_q};
            `STS_ADDR_STATUS:         prdata <= {16'h0, sample_cnt_q, 4'h0, state_q[3:1],
                                                 synced_flag_q};
            `STS_ADDR_SAMPLE_DATA:    prdata <= {{(32-W){1'b0}}, sample_data_o};
            `STS_ADDR_SAMPLE_CONFIG:  prdata <= {24'h0, odr_div_q};
            default:                  prdata <= 32'h0;
         endcase
      end
   end

   // Three-stage capture; level changes once stages two and three agree
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fs_q     <= 3'h0;
         i1_q     <= 3'h0;
         ec_q     <= 3'h0;
         fs_lvl_q <= 1'b0;
         i1_lvl_q <= 1'b0;
         ec_lvl_q <= 1'b0;
      end else begin
         fs_q <= {fs_q[1:0], frame_sync_pin_i};
         i1_q <= {i1_q[1:0], interrupt_pin_one_i};
         ec_q <= {ec_q[1:0], ext_clk_i};
         if (fs_q[1] == fs_q[2]) begin
            fs_lvl_q <= fs_q[2];
         end
         if (i1_q[1] == i1_q[2]) begin
            i1_lvl_q <= i1_q[2];
         end
         if (ec_q[1] == ec_q[2]) begin
            ec_lvl_q <= ec_q[2];
         end
      end
   end

   // Time base: internal oscillator or divided external clock
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         osc_cnt_q   <= 16'h0;
         ext_cnt_q   <= 4'h0;
         ec_prev_q   <= 1'b0;
         trig_prev_q <= 1'b0;
         sync_prev_q <= 1'b0;
         sys_tick_o  <= 1'b0;
      end else begin
         ec_prev_q   <= ec_lvl_q;
         trig_prev_q <= trig_lvl;
         sync_prev_q <= sync_lvl;
         sys_tick_o  <= tick;
         osc_cnt_q   <= osc_tick ? 16'h0 : osc_cnt_q + 16'h0001;
         if (ext_edge) begin
            ext_cnt_q <= ext_tick ? 4'h0 : ext_cnt_q + 4'h1;
         end
      end
   end

   // Output data rate counter; a sync edge in sync mode 01 restarts the phase
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         odr_cnt_q     <= 8'h0;
         synced_flag_q <= 1'b0;
      end else begin
         if (sync_on & (sync_mode == `STS_SYNC_EXT) & sync_edge) begin
            odr_cnt_q     <= 8'h0;
            synced_flag_q <= 1'b1;
         end else if (tick) begin
            odr_cnt_q <= odr_tick ? 8'h0 : odr_cnt_q + 8'h01;
         end
         if (~sync_on) begin
            synced_flag_q <= 1'b0;
         end
      end
   end

   // Trigger sequencer: one sample per accepted edge
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (trig_on & (trig_edge | trig_pending_q)) state_d = ST_WAIT;
         ST_WAIT: if (tick) state_d = ST_EMIT;
         ST_EMIT: state_d = ST_HOLD;
         ST_HOLD: if (~trig_lvl) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always @* begin
      sample_ready_d = 1'b0;
      if (trig_on) begin
         sample_ready_d = state_q == ST_EMIT;
      end else if (sync_on & (sync_mode == `STS_SYNC_INTERP)) begin
         sample_ready_d = sync_edge;
      end else if (sync_on & (sync_mode == `STS_SYNC_EXT)) begin
         sample_ready_d = sync_edge | odr_tick;
      end else if (~standby) begin
         sample_ready_d = odr_tick;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q        <= ST_IDLE;
         trig_pending_q <= 1'b0;
         sample_ready_o <= 1'b0;
         sample_data_o  <= {W{1'b0}};
         sample_cnt_q   <= 8'h0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE) begin
            trig_pending_q <= 1'b0;
         end else if (trig_edge) begin
            trig_pending_q <= 1'b1;
         end
         sample_ready_o <= sample_ready_d;
         if (sample_ready_d) begin
            sample_cnt_q <= sample_cnt_q + 8'h01;
            if (~(sync_on & (sync_mode == `STS_SYNC_INTERP))) begin
               sample_data_o <= raw_sample_i;
            end
         end
         if (sync_on & (sync_mode == `STS_SYNC_INTERP) & sample_ready_o) begin
            sample_data_o <= interp_val;
         end
      end
   end

   stsync_interp #(
      .W (W)
   ) u_interp (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .push_i    (push),
      .sample_i  (raw_sample_i),
      .take_i    (sync_edge & sync_on & (sync_mode == `STS_SYNC_INTERP)),
      .interp_o  (interp_val)
   );

   wire unused_ok = &{1'b0, PULSE_CYC[0], pwdata[31:8]};
endmodule // stsync_top
`default_nettype wire

// file: test/stsync_host.sv
`timescale 1ns/10ps
`default_nettype none
module stsync_host #(
   parameter int HOLD = 300,
   parameter int EXTH = 163
) (
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic sel_i,
   output logic      busy_o,
   output logic      frame_sync_pin_o,
   output logic      interrupt_pin_one_o,
   output logic      ext_clk_o
);
   int cnt_q = 0;
   // Free-running clock near 3.07 MHz, phase unrelated to clk_i
   initial begin
      ext_clk_o = 1'b0;
      #37;
      forever #EXTH ext_clk_o = ~ext_clk_o;
   end
   // High for HOLD cycles, then low for HOLD cycles before the next pulse
   always @(posedge clk_i) begin
      if (cnt_q != 0) cnt_q <= cnt_q - 1;
      else if (go_i) cnt_q <= 2 * HOLD;
   end
   assign busy_o = cnt_q != 0;
   assign frame_sync_pin_o = !sel_i && cnt_q > HOLD;
   assign interrupt_pin_one_o = sel_i && cnt_q > HOLD;
endmodule // stsync_host
`default_nettype wire

// file: test/stsync_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module stsync_chk (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        frame_sync_pin_i,
   input wire logic        interrupt_pin_one_i,
   input wire logic        sample_ready_o,
   input wire logic        sys_tick_o
);
   logic [2:0] mode_q;
   logic [6:4] sync_q;
   logic [1:0] trig_q;
   logic [7:0] gap_q;
   logic       ext_q;
   logic       run_q;
   wire acc = psel && penable;
   wire wr = acc && pwrite && pready;
   wire map = paddr == 32'h94 || paddr == 32'hd4 || paddr == 32'h124
              || (paddr >= 32'h140 && paddr <= 32'h14c && paddr[1:0] == 2'h0);
   wire spin = sync_q[6] ? interrupt_pin_one_i : frame_sync_pin_i;
   wire tpin = trig_q[1] ? interrupt_pin_one_i : frame_sync_pin_i;
   wire lown = mode_q <= 3'h2;
   wire trig = trig_q[0] && mode_q >= 3'h3 && mode_q <= 3'h5;
   // Shadow of the configuration, taken from completed bus writes
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_q <= 3'h7;
         sync_q <= 3'h0;
         trig_q <= 2'h0;
         gap_q <= 8'h00;
         ext_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         gap_q <= sys_tick_o ? 8'h00 : gap_q + 8'h01;
         if (wr && paddr == 32'h140) mode_q <= pwdata[2:0];
         if (wr && paddr == 32'hd4) sync_q <= pwdata[6:4];
         if (wr && paddr == 32'h124) trig_q <= pwdata[1:0];
         if (wr && paddr == 32'h94 && mode_q == 3'h7) begin
            ext_q <= |pwdata[1:0];
            run_q <= 1'b0;
         end else if (sys_tick_o) begin
            run_q <= !ext_q;
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_unmap_err: assert property (acc && !map |-> pslverr)
      else $error("unmapped access without error");
   chk_map_clean: assert property (pslverr |-> acc && !map)
      else $error("error on mapped or idle cycle");
   chk_unmap_zero: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_ready_pulse: assert property (
      sample_ready_o |=> !sample_ready_o) else $error("sample ready too wide");
   chk_tick_rate: assert property (
      sys_tick_o && run_q |-> gap_q == 8'd48) else $error("internal tick period wrong");
   chk_sync_align: assert property (
      $rose(spin) && sync_q[5:4] == 2'h1 && lown |-> ##[2:8] sample_ready_o)
      else $error("sample ready not aligned to sync");
   chk_trig_sample: assert property (
      $rose(tpin) && trig |-> ##[3:400] sample_ready_o)
      else $error("trigger gave no sample");
   chk_trig_once: assert property (
      trig && sample_ready_o |=> !sample_ready_o [*8]) else $error("extra sample");
endmodule // stsync_chk
bind stsync_top stsync_chk u_stsync_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .frame_sync_pin_i(frame_sync_pin_i), .interrupt_pin_one_i(interrupt_pin_one_i),
   .sample_ready_o(sample_ready_o), .sys_tick_o(sys_tick_o));
`default_nettype wire

// file: test/test_sample_timing_sync_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module test_sample_timing_sync_trigger;
   localparam int HOLD = 300;
   localparam int EXTH = 163;
   localparam logic [7:0] IDX [4] = '{8'h25, 8'h35, 8'h49, 8'h50};
   localparam logic [7:0] RSTV [4] = '{8'h00, 8'h00, 8'h00, 8'h07};
   localparam logic [7:0] MASK [3] = '{8'hff, 8'hdf, 8'hff};
   logic        clk_i, sys_rst_i, psel, penable, pwrite, e;
   logic        go, sel, busy, fs, i1, ek, pready, pslverr, rdy, tick;
   logic [31:0] paddr, pwdata, prdata, r;
   logic [15:0] raw, rd_data;
   int          n_mismatch, samples_checked, cyc, n_rdy, n_tick, d, v, s;
   stsync_top u_stsync_top (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ext_clk_i(ek), .frame_sync_pin_i(fs), .interrupt_pin_one_i(i1), .raw_sample_i(raw),
      .sample_ready_o(rdy), .sample_data_o(rd_data), .sys_tick_o(tick));
   stsync_host #(.HOLD(HOLD), .EXTH(EXTH)) u_stsync_host (
      .clk_i(clk_i), .go_i(go), .sel_i(sel), .busy_o(busy), .frame_sync_pin_o(fs),
      .interrupt_pin_one_o(i1), .ext_clk_o(ek));
   function automatic int exp_ticks(input int ext, input int div);
      return ext ? 98000 / ((div + 1) * 2 * EXTH) : 98000 / (49 * 20);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d compares %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pulse(input logic p);
      sel <= p;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy !== 1'b0) @(posedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Pulse counters and the hang limit
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      n_rdy = n_rdy + (rdy === 1'b1);
      n_tick = n_tick + (tick === 1'b1);
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      sys_rst_i = 1'b1;
      {psel, penable, pwrite, go, sel} = '0;
      {paddr, pwdata, raw} = '0;
      void'($urandom(91489));
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, IDX[k], 0);
         chk(r, RSTV[k]);
      end
      for (int k = 0; k < 3; k++) begin
         v = $urandom & MASK[k];
         apb(1'b1, IDX[k], v);
         apb(1'b0, IDX[k], 0);
         chk(r, v);
         apb(1'b1, IDX[k], 0);
      end
      apb(1'b0, 8'h10, 0);
      chk(r, 0);
      chk({31'h0, e}, 1);
      d = $urandom_range(15);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 8'h25, k ? 0 : {d[3:0], 4'h1});
         repeat (50) @(posedge clk_i);
         n_tick = 0;
         repeat (4900) @(posedge clk_i);
         v = exp_ticks(1 - k, d);
         chk(n_tick >= v - 2 && n_tick <= v + 2, 1);
      end
      apb(1'b1, 8'h50, 0);
      apb(1'b1, 8'h25, 8'hf1);
      apb(1'b0, 8'h25, 0);
      chk(r, 0);
      apb(1'b1, 8'h53, 2);
      n_rdy = 0;
      repeat (4900) @(posedge clk_i);
      chk(n_rdy >= 30 && n_rdy <= 51, 1);
      raw <= 16'($urandom);
      apb(1'b1, 8'h35, 8'h20);
      repeat (400) @(posedge clk_i);
      pulse(1'b0);
      chk({16'h0, rd_data}, {16'h0, raw});
      apb(1'b1, 8'h53, 8'h40);
      for (s = 0; s < 2; s++) begin
         apb(1'b1, 8'h35, s ? 8'h50 : 8'h10);
         pulse(s[0]);
         n_rdy = 0;
         pulse(s[0]);
         pulse(!s[0]);
         chk(n_rdy, 1);
      end
      apb(1'b1, 8'h35, 0);
      for (int m = 3; m < 6; m++) begin
         s = $urandom_range(1);
         apb(1'b1, 8'h50, m);
         apb(1'b1, 8'h49, s ? 3 : 1);
         n_rdy = 0;
         pulse(s[0]);
         pulse(!s[0]);
         chk(n_rdy, 1);
      end
      stop_test();
   end
endmodule // test_sample_timing_sync_trigger
`default_nettype wire
